/* verif/mac_engine_model.sv */
// Purpose: Behavioural MAC engine that answers launch pulses of the register bank.
// Assumes: One clock; each launch keeps its channel busy for HOLD cycles.
// Notes:   Data lines show the inverse of the current input value outside their strobe.
`timescale 1ns/10ps
`default_nettype none
module mac_engine_model
   import mac_tx_regs_pkg::*;
#(
   parameter int HOLD = 12
)(
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic                    normal_start,
   input  wire logic [N_SLOTF-1:0]      slot_start,
   input  wire logic                    ack_fp,
   input  wire logic [1:0]              retry_val,
   output logic                         normal_busy,
   output logic                         rx_ack_valid,
   output logic                         rx_ack_fp,
   output logic      [N_SLOTF-1:0]      slot_busy,
   output logic      [N_SLOTF-1:0]      slot_done,
   output logic      [N_SLOTF-1:0][1:0] slot_retry_used
);
   logic [2:0][3:0] cnt_q;
   logic [2:0]      go;
   logic [2:0]      fin;

   assign go = {slot_start, normal_start};

   // Channel 0 is the normal FIFO, channels 1 and 2 the slot FIFOs.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
      end else begin
         for (int k = 0; k < 3; k++) begin
            if (go[k]) begin
               cnt_q[k] <= 4'(HOLD);
            end else if (cnt_q[k] != 4'h0) begin
               cnt_q[k] <= cnt_q[k] - 4'h1;
            end
         end
      end
   end

   always_comb begin
      for (int k = 0; k < 3; k++) begin
         fin[k] = (cnt_q[k] == 4'h1);
      end
   end

   assign normal_busy  = (cnt_q[0] != 4'h0);
   assign rx_ack_valid = fin[0];
   assign rx_ack_fp    = fin[0] ? ack_fp : ~ack_fp;
   assign slot_busy    = {cnt_q[2] != 4'h0, cnt_q[1] != 4'h0};
   assign slot_done    = fin[2:1];
   assign slot_retry_used[0] = fin[1] ? retry_val : ~retry_val;
   assign slot_retry_used[1] = fin[2] ? retry_val : ~retry_val;
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// Purpose: Self-checking bench for the MAC transmit FIFO control registers.
// Assumes: Engine model keeps each launch busy for 12 cycles.
// Notes:   APB signals change right after rising edges; replies are taken at rising edges.
`timescale 1ns/10ps
`default_nettype none
module tb_top import mac_tx_regs_pkg::*;;
   logic              pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic              pwrite = 1'b0, ack_fp = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0, prdata;
   logic [3:0]        pstrb = '0;
   logic [1:0]        retry_val = 2'b00;
   logic              pready, pslverr, normal_busy, rx_ack_valid, rx_ack_fp, normal_start;
   logic              slot_fifo_alternate, ack_pending_value, immediate_wake_enable;
   logic              register_wake_pulse;
   logic [1:0]        slot_busy, slot_done, slot_start;
   logic [1:0][1:0]   slot_retry_used;
   normal_cfg_t       normal_cfg;
   slot_cfg_t [1:0]   slot_cfg;
   logic [4:0][3:0]   end_slot;
   logic [5:0]        min_long_interframe_spacing, beacon_start_interval;
   int                bad_count = 0, check_count = 0;
   wire [4:0]         ev = {slot_done, slot_start, normal_start};
   localparam logic [7:0] RA [5] = '{8'h78, 8'h7c, 8'h80, 8'h84, 8'h88};
   localparam logic [7:0] WD [5] = '{8'ha5, 8'h3c, 8'hff, 8'h7f, 8'hc5};
   localparam logic [7:0] RX [5] = '{8'ha5, 8'h3c, 8'h0f, 8'h7f, 8'hc5};

   mac_tx_fifo_control_regs mac_tx_fifo_control_regs_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .normal_busy(normal_busy), .rx_ack_valid(rx_ack_valid), .rx_ack_fp(rx_ack_fp),
      .slot_busy(slot_busy), .slot_done(slot_done), .slot_retry_used(slot_retry_used),
      .normal_start(normal_start), .normal_cfg(normal_cfg), .slot_start(slot_start),
      .slot_cfg(slot_cfg), .end_slot(end_slot),
      .min_long_interframe_spacing(min_long_interframe_spacing),
      .slot_fifo_alternate(slot_fifo_alternate), .ack_pending_value(ack_pending_value),
      .immediate_wake_enable(immediate_wake_enable),
      .register_wake_pulse(register_wake_pulse), .beacon_start_interval(beacon_start_interval));

   mac_engine_model #(.HOLD(12)) mac_engine_model_i (.pclk(pclk), .presetn(presetn),
      .normal_start(normal_start), .slot_start(slot_start), .ack_fp(ack_fp),
      .retry_val(retry_val), .normal_busy(normal_busy), .rx_ack_valid(rx_ack_valid),
      .rx_ack_fp(rx_ack_fp), .slot_busy(slot_busy), .slot_done(slot_done),
      .slot_retry_used(slot_retry_used));

   task automatic wrap_up();
      $display("checks %0d errors %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      check_count++;
      if (got !== ex) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, ex, got);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge pclk);
      penable <= 1'b1;
      // The request stands until the rising edge at which pready is seen high.
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         bad_count++;
         wrap_up();
      end
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s = 4'h1);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, {24'h0, d}, s, r, e);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] ex, input string nm);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, '0, 4'h0, r, e);
      chk(nm, {24'h0, ex}, r);
   endtask

   // Looks for a pulse on one event line during eight cycles.
   task automatic watch(input int k, input logic ex, input string nm);
      logic seen;
      seen = 1'b0;
      repeat (8) begin
         @(negedge pclk);
         if (ev[k] === 1'b1) seen = 1'b1;
      end
      chk(nm, {31'h0, ex}, {31'h0, seen});
   endtask

   task automatic reset_values();
      for (int k = 0; k < 8; k++) begin
         rd(8'h6c + 8'(4 * k), (k == 6) ? 8'h84 : 8'h00, "reset");
      end
      chk("spacing out", 32'h21, {26'h0, min_long_interframe_spacing});
      chk("wake outs", 0, {immediate_wake_enable, beacon_start_interval, normal_cfg});
   endtask

   task automatic plain_regs();
      logic [31:0] r;
      logic        e;
      for (int k = 0; k < 5; k++) begin
         wr(RA[k], WD[k]);
         rd(RA[k], RX[k], "rw reg");
      end
      chk("end slots", 32'hf3ca5, {12'h0, end_slot});
      chk("pend outs", 32'h7f, {24'h0, min_long_interframe_spacing, slot_fifo_alternate,
          ack_pending_value});
      chk("wake outs", 32'hc5, {24'h0, immediate_wake_enable, register_wake_pulse,
          beacon_start_interval});
      wr(8'h88, 8'h85);
      @(negedge pclk);
      chk("wake bit", 0, {31'h0, register_wake_pulse});
      wr(8'h84, 8'h00, 4'h0);
      rd(8'h84, 8'h7f, "masked write");
      apb(1'b0, 8'h00, '0, 4'h0, r, e);
      chk("unmapped err", 1, {31'h0, e});
      chk("unmapped data", 0, r);
   endtask

   task automatic normal_launch(input logic [7:0] d, input logic [2:0] cf, input logic fp);
      ack_fp <= fp;
      wr(8'h6c, d);
      watch(0, 1'b1, "normal start");
      chk("normal cfg", {29'h0, cf}, {29'h0, normal_cfg});
      // Trigger again while busy, then write a zero trigger; the launch must survive.
      wr(8'h6c, 8'h01);
      wr(8'h6c, 8'h0e);
      watch(0, 1'b1, "pending start");
      chk("relaunch cfg", 32'h7, {29'h0, normal_cfg});
      watch(0, 1'b0, "no restart");
      rd(8'h6c, {3'b000, fp, 4'h0}, "normal after ack");
   endtask

   task automatic slot_launch(input int i, input logic [2:0] sl, input logic [1:0] rv);
      retry_val <= rv;
      wr(8'h70 + 8'(4 * i), {2'b11, sl, 3'b111});
      watch(i + 1, 1'b1, "slot start");
      chk("slot cfg", {25'h0, 2'b11, sl, 2'b11}, {25'h0, slot_cfg[i]});
      watch(i + 3, 1'b1, "slot done");
      rd(8'h70 + 8'(4 * i), {rv, sl, 3'b110}, "slot after");
   endtask

   initial begin
      forever #4 pclk = ~pclk;
   end

   initial begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      wrap_up();
   end

   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      reset_values();
      plain_regs();
      normal_launch(8'h07, 3'b011, 1'b1);
      normal_launch(8'h09, 3'b100, 1'b0);
      slot_launch(0, 3'h5, 2'b01);
      slot_launch(1, 3'h2, 2'b10);
      wrap_up();
   end
endmodule
`default_nettype wire

/* verilog/mac_tx_fifo_control_regs.sv */
// Purpose: APB register bank for the MAC transmit FIFO controls.
// Assumes: MAC engine signals share pclk; APB master obeys APB4 timing.
// Notes:   One wait-free access phase follows each setup; pready rises then.
// How it works
// - Writing one to the normal trigger launches the normal FIFO frame, then self-clears.
// - Writing one to slot FIFO 1 trigger launches its frame, then self-clears.
// - Writing one to slot FIFO 2 trigger launches its frame, then self-clears.
// - Acknowledgement-request bit asks engine to expect an ack and retransmit; resets zero.
// - Security-enable bit makes the engine secure that FIFO's frame; resets zero.
// - Read-only status bit shows frame-pending flag of the last received ack.
// - Indirect bit marks the normal frame as indirect, coordinator only; resets zero.
// - Indirect, ack-request and security bits of normal FIFO clear at next trigger.
// - Slot retry field: write sets retry limit, read returns retries actually used.
// - Three-bit slot field picks the guaranteed slot each slot FIFO uses.
// - Four-bit end slots of slots two to six, higher slot in upper nibble.
// - Long interframe spacing field, six bits, resets to 0x21.
// - Alternate bit keeps slot FIFOs toggling through the contention-free period.
// - Host frame-pending value is copied into outgoing acknowledgement frames.
// - Immediate wake enable bit, reset zero.
// - Six-bit beacon start interval, reset zero.
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module mac_tx_fifo_control_regs
   import mac_tx_regs_pkg::*;
(
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [ADDR_W-1:0]        paddr,
   input  wire logic [DATA_W-1:0]        pwdata,
   input  wire logic [3:0]               pstrb,
   output logic      [DATA_W-1:0]        prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire logic                     normal_busy,
   input  wire logic                     rx_ack_valid,
   input  wire logic                     rx_ack_fp,
   input  wire logic [N_SLOTF-1:0]       slot_busy,
   input  wire logic [N_SLOTF-1:0]       slot_done,
   input  wire logic [N_SLOTF-1:0][1:0]  slot_retry_used,
   output logic                          normal_start,
   output normal_cfg_t                   normal_cfg,
   output logic      [N_SLOTF-1:0]       slot_start,
   output slot_cfg_t [N_SLOTF-1:0]       slot_cfg,
   output logic      [N_END-1:0][3:0]    end_slot,
   output logic      [5:0]               min_long_interframe_spacing,
   output logic                          slot_fifo_alternate,
   output logic                          ack_pending_value,
   output logic                          immediate_wake_enable,
   output logic                          register_wake_pulse,
   output logic      [5:0]               beacon_start_interval
);

   logic                    setup;
   logic                    wr_en;
   logic                    mapped;
   logic [7:0]              wbyte;
   logic [7:0]              rd_byte;
   logic                    wr_normal;
   logic                    wr_end32;
   logic                    wr_end54;
   logic                    wr_end6;
   logic                    wr_pend;
   logic                    wr_wake;
   logic [N_SLOTF-1:0]      wr_slot;
   logic [N_SLOTF-1:0][7:0] slot_rd;
   logic                    normal_trig_q;
   logic                    normal_trig_d;
   logic                    normal_start_d;
   normal_cfg_t             normal_ctl_q;
   logic                    rx_fp_q;

   assign setup  = psel & ~penable;
   // Only the low byte lane carries register data.
   assign wr_en  = psel & penable & pready & pwrite & pstrb[0];
   assign wbyte  = pwdata[7:0];
   assign mapped = addr_hit(paddr, IDX_NORMAL) | addr_hit(paddr, IDX_SLOT1)
                 | addr_hit(paddr, IDX_SLOT2)  | addr_hit(paddr, IDX_END_32)
                 | addr_hit(paddr, IDX_END_54) | addr_hit(paddr, IDX_END_6)
                 | addr_hit(paddr, IDX_PEND)   | addr_hit(paddr, IDX_WAKE);

   assign wr_normal  = wr_en & addr_hit(paddr, IDX_NORMAL);
   assign wr_slot[0] = wr_en & addr_hit(paddr, IDX_SLOT1);
   assign wr_slot[1] = wr_en & addr_hit(paddr, IDX_SLOT2);
   assign wr_end32   = wr_en & addr_hit(paddr, IDX_END_32);
   assign wr_end54   = wr_en & addr_hit(paddr, IDX_END_54);
   assign wr_end6    = wr_en & addr_hit(paddr, IDX_END_6);
   assign wr_pend    = wr_en & addr_hit(paddr, IDX_PEND);
   assign wr_wake    = wr_en & addr_hit(paddr, IDX_WAKE);

   // The APB slave answers in the first access cycle; unmapped words err.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~mapped;
         if (setup && !pwrite) begin
            prdata <= {24'h000000, rd_byte};
         end
      end
   end

   always_comb begin
      rd_byte = 8'h00;
      if (addr_hit(paddr, IDX_NORMAL)) begin
         rd_byte[RXFP_BIT]   = rx_fp_q;
         rd_byte[IND_BIT]    = normal_ctl_q.indirect;
         rd_byte[ACK_BIT]    = normal_ctl_q.ack_req;
         rd_byte[SEC_BIT]    = normal_ctl_q.sec_en;
         rd_byte[TRIG_BIT]   = normal_trig_q;
      end else if (addr_hit(paddr, IDX_SLOT1)) begin
         rd_byte = slot_rd[0];
      end else if (addr_hit(paddr, IDX_SLOT2)) begin
         rd_byte = slot_rd[1];
      end else if (addr_hit(paddr, IDX_END_32)) begin
         rd_byte = {end_slot[1], end_slot[0]};
      end else if (addr_hit(paddr, IDX_END_54)) begin
         rd_byte = {end_slot[3], end_slot[2]};
      end else if (addr_hit(paddr, IDX_END_6)) begin
         rd_byte = {4'h0, end_slot[4]};
      end else if (addr_hit(paddr, IDX_PEND)) begin
         rd_byte = {min_long_interframe_spacing, slot_fifo_alternate, ack_pending_value};
      end else if (addr_hit(paddr, IDX_WAKE)) begin
         rd_byte = {immediate_wake_enable, register_wake_pulse, beacon_start_interval};
      end
   end

   // Normal FIFO launch: the trigger waits while the engine is busy.
   assign normal_start_d = normal_trig_q & ~normal_busy & ~normal_start;
   // A one written during a launch cycle survives; a zero changes nothing.
   assign normal_trig_d  = (normal_trig_q & ~normal_start_d)
                         | (wr_normal & wbyte[TRIG_BIT]);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         normal_trig_q <= 1'b0;
         normal_start  <= 1'b0;
      end else begin
         normal_trig_q <= normal_trig_d;
         normal_start  <= normal_start_d;
      end
   end

   // The launched frame carries the options latched at launch; the register
   // copies are then cleared, but a write in the same cycle wins.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         normal_ctl_q <= '0;
         normal_cfg   <= '0;
      end else begin
         if (normal_start_d) begin
            normal_cfg <= normal_ctl_q;
         end
         if (wr_normal) begin
            normal_ctl_q.indirect <= wbyte[IND_BIT];
            normal_ctl_q.ack_req  <= wbyte[ACK_BIT];
            normal_ctl_q.sec_en   <= wbyte[SEC_BIT];
         end else if (normal_start_d) begin
            normal_ctl_q <= '0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_fp_q <= 1'b0;
      end else if (rx_ack_valid) begin
         rx_fp_q <= rx_ack_fp;
      end
   end

   genvar g;
   generate
      for (g = 0; g < N_SLOTF; g++) begin : g_slot
         slot_fifo_ctl u_slot (
            .pclk       (pclk),
            .presetn    (presetn),
            .wr_en      (wr_slot[g]),
            .wdata      (wbyte),
            .busy       (slot_busy[g]),
            .done       (slot_done[g]),
            .retry_used (slot_retry_used[g]),
            .rd_value   (slot_rd[g]),
            .start      (slot_start[g]),
            .cfg        (slot_cfg[g])
         );
      end
   endgenerate

   // End slots of guaranteed slots two to six.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         end_slot <= {N_END{END_RST}};
      end else begin
         if (wr_end32) begin
            end_slot[0] <= wbyte[3:0];
            end_slot[1] <= wbyte[7:4];
         end
         if (wr_end54) begin
            end_slot[2] <= wbyte[3:0];
            end_slot[3] <= wbyte[7:4];
         end
         if (wr_end6) begin
            // Fifteen is needed here when a seventh slot exists.
            end_slot[4] <= wbyte[3:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         min_long_interframe_spacing <= SPACE_RST;
         slot_fifo_alternate         <= 1'b0;
         ack_pending_value           <= 1'b0;
      end else if (wr_pend) begin
         min_long_interframe_spacing <= wbyte[SPACE_LSB +: 6];
         slot_fifo_alternate         <= wbyte[ALT_BIT];
         ack_pending_value           <= wbyte[ACKFP_BIT];
      end
   end

   // The wake pulse is a plain level the host raises and lowers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         immediate_wake_enable <= 1'b0;
         register_wake_pulse   <= 1'b0;
         beacon_start_interval <= IVAL_RST;
      end else if (wr_wake) begin
         immediate_wake_enable <= wbyte[IMM_BIT];
         register_wake_pulse   <= wbyte[REGW_BIT];
         beacon_start_interval <= wbyte[IVAL_LSB +: 6];
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_normal_launch: assert property (
      normal_trig_q && !normal_busy && !normal_start |=> normal_start ##1 !normal_start
   ) else $error("normal trigger did not launch once");

   a_normal_selfclear: assert property (
      normal_start && !$past(wr_normal) |-> !normal_trig_q
   ) else $error("normal trigger not cleared at launch");

   a_zero_write_inert: assert property (
      wr_normal && !wbyte[TRIG_BIT] && normal_trig_q && normal_busy |=> normal_trig_q
   ) else $error("zero write cancelled a pending trigger");

   a_options_cleared: assert property (
      normal_start && !$past(wr_normal) |-> normal_ctl_q == '0
   ) else $error("normal options not cleared at trigger");

   a_launch_options: assert property (
      normal_start |-> normal_cfg == $past(normal_ctl_q)
   ) else $error("launched options differ from register");

   a_ack_fp_status: assert property (
      rx_ack_valid |=> rx_fp_q == $past(rx_ack_fp)
   ) else $error("frame pending status not captured");

   a_slot1_launch: assert property (
      slot_start[0] |=> !slot_start[0]
   ) else $error("slot one launch longer than a cycle");

   a_slot2_launch: assert property (
      slot_start[1] |=> !slot_start[1]
   ) else $error("slot two launch longer than a cycle");

   a_ack_value: assert property (
      wr_pend |=> ack_pending_value == $past(wbyte[ACKFP_BIT])
   ) else $error("ack pending value not written");

   a_wake_enable: assert property (
      wr_wake |=> immediate_wake_enable == $past(wbyte[IMM_BIT])
   ) else $error("immediate wake enable not written");

   a_interval_hold: assert property (
      !wr_wake |=> $stable(beacon_start_interval)
   ) else $error("beacon interval changed without a write");

   a_apb_answer: assert property (
      setup |=> pready ##1 !pready
   ) else $error("APB answer not one access cycle");

   a_apb_error: assert property (
      setup |=> pslverr == !$past(mapped)
   ) else $error("APB error response wrong");

   a_normal_busy_wait: assert property (
      normal_busy |=> !normal_start
   ) else $error("normal launch while engine busy");

   a_slot1_selfclear: assert property (
      slot_start[0] && !$past(wr_slot[0]) |-> !slot_rd[0][TRIG_BIT]
   ) else $error("slot one trigger not cleared at launch");

   a_slot2_selfclear: assert property (
      slot_start[1] && !$past(wr_slot[1]) |-> !slot_rd[1][TRIG_BIT]
   ) else $error("slot two trigger not cleared at launch");

   a_slot1_busy_wait: assert property (
      slot_busy[0] |=> !slot_start[0]
   ) else $error("slot one launch while engine busy");

   a_slot2_busy_wait: assert property (
      slot_busy[1] |=> !slot_start[1]
   ) else $error("slot two launch while engine busy");

   a_retry_readback: assert property (
      slot_done[0] |=> slot_rd[0][RETRY_LSB +: 2] == $past(slot_retry_used[0])
   ) else $error("slot one retry count not captured");

   a_slot_select: assert property (
      wr_slot[1] |=> slot_cfg[1].slot == $past(wbyte[SLOT_LSB +: 3])
   ) else $error("slot two slot field not written");

   a_slot_options: assert property (
      wr_slot[0] |=> {slot_cfg[0].ack_req, slot_cfg[0].sec_en}
                     == $past({wbyte[ACK_BIT], wbyte[SEC_BIT]})
   ) else $error("slot one options not written");

   a_end_slots: assert property (
      wr_end54 |=> end_slot[3:2] == $past(wbyte)
   ) else $error("end slots four and five not written");

   a_spacing_write: assert property (
      wr_pend |=> min_long_interframe_spacing == $past(wbyte[SPACE_LSB +: 6])
   ) else $error("interframe spacing not written");

   a_alternate_write: assert property (
      wr_pend |=> slot_fifo_alternate == $past(wbyte[ALT_BIT])
   ) else $error("slot alternate bit not written");

   a_wake_pulse: assert property (
      wr_wake |=> register_wake_pulse == $past(wbyte[REGW_BIT])
   ) else $error("register wake bit not written");

endmodule
`default_nettype wire

/* verilog/mac_tx_regs_pkg.sv */
// Purpose: Shared constants and carriers for the MAC transmit FIFO control registers.
// Assumes: Registers sit on APB at byte address four times the register index.
// Notes:   Registers are eight bits wide in the low byte of each word.
package mac_tx_regs_pkg;

   localparam int unsigned ADDR_W  = 8;
   localparam int unsigned DATA_W  = 32;
   localparam int unsigned IDX_W   = 6;
   localparam int unsigned N_SLOTF = 2;
   localparam int unsigned N_END   = 5;

   // Register indices; the byte address is the index times four.
   localparam logic [IDX_W-1:0] IDX_NORMAL   = 6'h1b;
   localparam logic [IDX_W-1:0] IDX_SLOT1    = 6'h1c;
   localparam logic [IDX_W-1:0] IDX_SLOT2    = 6'h1d;
   localparam logic [IDX_W-1:0] IDX_END_32   = 6'h1e;
   localparam logic [IDX_W-1:0] IDX_END_54   = 6'h1f;
   localparam logic [IDX_W-1:0] IDX_END_6    = 6'h20;
   localparam logic [IDX_W-1:0] IDX_PEND     = 6'h21;
   localparam logic [IDX_W-1:0] IDX_WAKE     = 6'h22;

   // Field positions.
   localparam int unsigned TRIG_BIT   = 0;
   localparam int unsigned SEC_BIT    = 1;
   localparam int unsigned ACK_BIT    = 2;
   localparam int unsigned IND_BIT    = 3;
   localparam int unsigned RXFP_BIT   = 4;
   localparam int unsigned SLOT_LSB   = 3;
   localparam int unsigned RETRY_LSB  = 6;
   localparam int unsigned ACKFP_BIT  = 0;
   localparam int unsigned ALT_BIT    = 1;
   localparam int unsigned SPACE_LSB  = 2;
   localparam int unsigned IVAL_LSB   = 0;
   localparam int unsigned REGW_BIT   = 6;
   localparam int unsigned IMM_BIT    = 7;

   // Reset values.
   localparam logic [5:0] SPACE_RST = 6'h21;
   localparam logic [5:0] IVAL_RST  = 6'h00;
   localparam logic [3:0] END_RST   = 4'h0;

   typedef struct packed {
      logic indirect;
      logic ack_req;
      logic sec_en;
   } normal_cfg_t;

   typedef struct packed {
      logic [1:0] retry_limit;
      logic [2:0] slot;
      logic       ack_req;
      logic       sec_en;
   } slot_cfg_t;

   function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [IDX_W-1:0] idx);
      return a == {idx, 2'b00};
   endfunction

endpackage

/* verilog/slot_fifo_ctl.sv */
// Purpose: Control register of one guaranteed-slot transmit FIFO.
// Assumes: Write strobe and data come from the APB slave on the same clock.
// Notes:   Retry field reads back the retries used, not the limit written.
`timescale 1ns/10ps
`default_nettype none
module slot_fifo_ctl
   import mac_tx_regs_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       wr_en,
   input  wire logic [7:0] wdata,
   input  wire logic       busy,
   input  wire logic       done,
   input  wire logic [1:0] retry_used,
   output logic      [7:0] rd_value,
   output logic            start,
   output slot_cfg_t       cfg
);

   logic       trig_q;
   logic       trig_d;
   logic       start_d;
   logic [1:0] used_q;

   assign start_d  = trig_q & ~busy & ~start;
   // A new trigger written while the old one launches is kept.
   assign trig_d   = (trig_q & ~start_d) | (wr_en & wdata[TRIG_BIT]);
   assign rd_value = {used_q, cfg.slot, cfg.ack_req, cfg.sec_en, trig_q};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_q <= 1'b0;
         start  <= 1'b0;
      end else begin
         trig_q <= trig_d;
         start  <= start_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg <= '0;
      end else if (wr_en) begin
         cfg.retry_limit <= wdata[RETRY_LSB +: 2];
         cfg.slot        <= wdata[SLOT_LSB +: 3];
         cfg.ack_req     <= wdata[ACK_BIT];
         cfg.sec_en      <= wdata[SEC_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         used_q <= 2'h0;
      end else if (done) begin
         used_q <= retry_used;
      end
   end

endmodule
`default_nettype wire
